// ### uart_flags_top.sv
`timescale 1ns/1ps
module uart_flags_top
  import uart_flags_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // serial line
  input  wire logic        rx_serial_input,
  output logic             tx_serial_output,
  // interrupt
  output logic             irq
);
  import uart_flags_pkg::*;

  typedef struct packed {
    logic [31:0]       prdata;
    logic              wide_char_sel;
    logic              par_en;
    logic              par_odd;
    logic              tx_on;
    logic              rx_on;
    logic              tx_ninth_bit;
    logic              rx_ninth_bit;
    logic [BAUD_W-1:0] baud;
    logic [BAUD_W-1:0] baud_cnt;
    // receive buffer and its flags
    logic [7:0]        rx_data;
    logic              receive_full_flag;
    logic              idle_flag;
    logic              overrun_flag;
    logic              noise_flag;
    logic              framing_error_flag;
    logic              parity_error_flag;
    // what the last status read showed, then idle arming and the transmit flags
    logic              arm_full;
    logic              arm_idle;
    logic              idle_armed;
    logic              tx_buffer_empty_flag;
    logic              tx_complete_flag;
    // transmit buffer, the word handed to the shifter, and the last receive line level
    logic [7:0]        tx_buf;
    logic              tx_load;
    logic [8:0]        tx_word;
    logic              rxd_q;
    // sticky events and their mask
    logic [EV_W-1:0]   evt;
    logic [EV_W-1:0]   evt_mask;
    logic              irq;
  } main_s;

  main_s           s;
  main_s           next_s;
  logic            tick;
  logic            rd_go;
  logic            wr_go;
  logic            read_done;
  logic [31:0]     rword;
  logic [EV_W-1:0] ev_set;
  logic [EV_W-1:0] ev_clr;
  logic            rx_valid;
  logic [8:0]      rx_char;
  logic            rx_noise;
  logic            rx_framing;
  logic            rx_parity;
  logic            rx_idle_seen;
  logic            tx_busy;
  logic            st_rd;
  logic            dat_rd;
  logic            ev_wr;
  logic            rx_fall;

  function automatic logic at(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // psel with penable marks the one cycle in which a transfer is taken
  function automatic logic in_access(input logic sel, input logic en);
    return sel & en;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return at(a, OFF_LINE_STATUS) | at(a, OFF_DATA) | at(a, OFF_CTRL_ONE)
         | at(a, OFF_CTRL_TWO) | at(a, OFF_CTRL_THREE) | at(a, OFF_BAUD)
         | at(a, OFF_EVENT) | at(a, OFF_EVENT_MASK);
  endfunction

  // receiver hands each finished character over for a single cycle
  uart_rx_sampler u_rx (
    .pclk         (pclk),
    .presetn      (presetn),
    .tick         (tick),
    .rx_on        (s.rx_on),
    .wide         (s.wide_char_sel),
    .par_en       (s.par_en),
    .par_odd      (s.par_odd),
    .rxd          (rx_serial_input),
    .char_valid   (rx_valid),
    .char_data    (rx_char),
    .char_noise   (rx_noise),
    .char_framing (rx_framing),
    .char_parity  (rx_parity),
    .idle_seen    (rx_idle_seen)
  );

  // shifter takes a character only while idle, busy until its stop bit ends
  uart_tx_shifter u_tx (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick      (tick),
    .wide      (s.wide_char_sel),
    .par_en    (s.par_en),
    .par_odd   (s.par_odd),
    .load      (s.tx_load),
    .load_data (s.tx_word),
    .txd       (tx_serial_output),
    .busy      (tx_busy)
  );

  // read word, captured in the setup phase so prdata comes from a flop
  always_comb
  begin
    rword = 32'h0000_0000;
    case (paddr)
      OFF_LINE_STATUS:
      begin
        rword[LS_TX_EMPTY]  = s.tx_buffer_empty_flag;
        rword[LS_TX_DONE]   = s.tx_complete_flag;
        rword[LS_RX_FULL]   = s.receive_full_flag;
        rword[LS_IDLE_LINE] = s.idle_flag;
        rword[LS_OVERRUN]   = s.overrun_flag;
        rword[LS_NOISE]     = s.noise_flag;
        rword[LS_FRAMING]   = s.framing_error_flag;
        rword[LS_PARITY]    = s.parity_error_flag;
      end
      OFF_DATA:
        rword[7:0] = s.rx_data;
      OFF_CTRL_ONE:
      begin
        rword[C1_WIDE]    = s.wide_char_sel;
        rword[C1_PAR_EN]  = s.par_en;
        rword[C1_PAR_ODD] = s.par_odd;
      end
      OFF_CTRL_TWO:
      begin
        rword[C2_TX_ON] = s.tx_on;
        rword[C2_RX_ON] = s.rx_on;
      end
      OFF_CTRL_THREE:
      begin
        rword[C3_RX_NINTH] = s.rx_ninth_bit;
        rword[C3_TX_NINTH] = s.tx_ninth_bit;
      end
      OFF_BAUD:
        rword[BAUD_W-1:0] = s.baud;
      OFF_EVENT:
        rword[EV_W-1:0] = s.evt;
      OFF_EVENT_MASK:
        rword[EV_W-1:0] = s.evt_mask;
      default:
        rword = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    next_s = s;
    rd_go = in_access(psel, penable) & !pwrite;
    wr_go = in_access(psel, penable) & pwrite & mapped(paddr);
    st_rd = rd_go & at(paddr, OFF_LINE_STATUS);
    dat_rd = rd_go & at(paddr, OFF_DATA);
    ev_wr = wr_go & at(paddr, OFF_EVENT);
    if (psel && !penable)
      next_s.prdata = rword;

    // baud divider gives the 16x tick; zero divisor stops both shifters
    tick = (s.baud != '0) && (s.baud_cnt == '0);
    if (s.baud_cnt == '0)
      next_s.baud_cnt = (s.baud == '0) ? '0 : s.baud - 1'b1;
    else
      next_s.baud_cnt = s.baud_cnt - 1'b1;

    // arming uses the value software actually saw in line_status_reg
    if (st_rd)
    begin
      next_s.arm_full = s.prdata[LS_RX_FULL];
      next_s.arm_idle = s.prdata[LS_IDLE_LINE];
    end
    // any data read disarms, so an old status read cannot clear a later character
    read_done = dat_rd && s.arm_full;
    if (dat_rd)
    begin
      if (s.arm_full)
      begin
        next_s.receive_full_flag = 1'b0;
        next_s.overrun_flag = 1'b0;
        next_s.noise_flag = 1'b0;
        next_s.framing_error_flag = 1'b0;
        next_s.parity_error_flag = 1'b0;
      end
      if (s.arm_idle)
        next_s.idle_flag = 1'b0;
      next_s.arm_full = 1'b0;
      next_s.arm_idle = 1'b0;
    end

    // a buffer being emptied this cycle can take the new character
    if (rx_valid)
    begin
      if (s.receive_full_flag && !read_done)
        next_s.overrun_flag = 1'b1;
      else
      begin
        next_s.receive_full_flag = 1'b1;
        next_s.rx_data = rx_char[7:0];
        if (s.wide_char_sel)
          next_s.rx_ninth_bit = rx_char[8];
        next_s.noise_flag = rx_noise;
        next_s.framing_error_flag = rx_framing;
        next_s.parity_error_flag = rx_parity;
        next_s.idle_armed = 1'b1;
      end
    end
    // idle fires once after a burst, then waits for a new character
    if (rx_idle_seen && s.idle_armed)
    begin
      next_s.idle_flag = 1'b1;
      next_s.idle_armed = 1'b0;
    end

    // transmit buffer to shifter; the held ninth bit rides along
    next_s.tx_load = 1'b0;
    if (!s.tx_buffer_empty_flag && !tx_busy && !s.tx_load && s.tx_on)
    begin
      next_s.tx_load = 1'b1;
      next_s.tx_word = {s.wide_char_sel & s.tx_ninth_bit, s.tx_buf};
      next_s.tx_buffer_empty_flag = 1'b1;
    end
    // done needs an empty buffer, an idle shifter and no load in flight
    next_s.tx_complete_flag = s.tx_buffer_empty_flag & !tx_busy & !s.tx_load;

    // register writes; a data write after a load refills the buffer
    if (wr_go)
    begin
      case (paddr)
        OFF_DATA:
        begin
          next_s.tx_buf = pwdata[7:0];
          next_s.tx_buffer_empty_flag = 1'b0;
          next_s.tx_complete_flag = 1'b0;
        end
        OFF_CTRL_ONE:
        begin
          next_s.wide_char_sel = pwdata[C1_WIDE];
          next_s.par_en = pwdata[C1_PAR_EN];
          next_s.par_odd = pwdata[C1_PAR_ODD];
        end
        OFF_CTRL_TWO:
        begin
          next_s.tx_on = pwdata[C2_TX_ON];
          next_s.rx_on = pwdata[C2_RX_ON];
        end
        OFF_CTRL_THREE:
          next_s.tx_ninth_bit = pwdata[C3_TX_NINTH];
        OFF_BAUD:
        begin
          // restart the divider so a new rate takes hold at once
          next_s.baud = pwdata[BAUD_W-1:0];
          next_s.baud_cnt = '0;
        end
        OFF_EVENT_MASK:
          next_s.evt_mask = pwdata[EV_W-1:0];
        default:
          next_s.baud = next_s.baud;
      endcase
    end

    // sticky events; a new event in the clearing cycle survives
    next_s.rxd_q = rx_serial_input;
    // rxd_q resets to the idle level, so no false edge follows reset
    rx_fall = s.rxd_q & !rx_serial_input;
    ev_set = '0;
    ev_set[EV_RX_EDGE]  = s.rx_on & rx_fall;
    ev_set[EV_RX_FULL]  = next_s.receive_full_flag & !s.receive_full_flag;
    ev_set[EV_IDLE]     = next_s.idle_flag & !s.idle_flag;
    ev_set[EV_OVERRUN]  = next_s.overrun_flag & !s.overrun_flag;
    ev_set[EV_TX_EMPTY] = next_s.tx_buffer_empty_flag & !s.tx_buffer_empty_flag;
    ev_set[EV_TX_DONE]  = next_s.tx_complete_flag & !s.tx_complete_flag;
    ev_clr = ev_wr ? pwdata[EV_W-1:0] : '0;
    next_s.evt = (s.evt & ~ev_clr) | ev_set;

    // registered so the pin cannot glitch while the bus decodes an address
    next_s.irq = |(next_s.evt & next_s.evt_mask);
  end

  // transmit side leaves reset empty and done, with the line idle high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.baud <= RST_BAUD;
      s.tx_buffer_empty_flag <= RST_TX_EMPTY;
      s.tx_complete_flag <= RST_TX_DONE;
      s.rxd_q <= RST_LINE;
    end
    else
      s <= next_s;
  end

  assign prdata  = s.prdata;
  assign pready  = 1'b1;
  // error only in the access phase; a setup cycle alone never flags
  assign pslverr = in_access(psel, penable) & !mapped(paddr);
  // masked-off transmit events stay visible but never interrupt
  assign irq     = s.irq;
endmodule

// ### uart_flags_pkg.sv
package uart_flags_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_LINE_STATUS = 8'h00;
  localparam logic [7:0] OFF_DATA        = 8'h04;
  localparam logic [7:0] OFF_CTRL_ONE    = 8'h08;
  localparam logic [7:0] OFF_CTRL_TWO    = 8'h0C;
  localparam logic [7:0] OFF_CTRL_THREE  = 8'h10;
  localparam logic [7:0] OFF_BAUD        = 8'h14;
  localparam logic [7:0] OFF_EVENT       = 8'h18;
  localparam logic [7:0] OFF_EVENT_MASK  = 8'h1C;

  // line_status_reg fields
  localparam int LS_TX_EMPTY  = 7;
  localparam int LS_TX_DONE   = 6;
  localparam int LS_RX_FULL   = 5;
  localparam int LS_IDLE_LINE = 4;
  localparam int LS_OVERRUN   = 3;
  localparam int LS_NOISE     = 2;
  localparam int LS_FRAMING   = 1;
  localparam int LS_PARITY    = 0;

  // control fields
  localparam int C1_WIDE      = 4;
  localparam int C1_PAR_EN    = 1;
  localparam int C1_PAR_ODD   = 0;
  localparam int C2_TX_ON     = 3;
  localparam int C2_RX_ON     = 2;
  localparam int C3_RX_NINTH  = 7;
  localparam int C3_TX_NINTH  = 6;

  // event status and mask fields
  localparam int EV_W         = 6;
  localparam int EV_RX_EDGE   = 0;
  localparam int EV_RX_FULL   = 1;
  localparam int EV_IDLE      = 2;
  localparam int EV_OVERRUN   = 3;
  localparam int EV_TX_EMPTY  = 4;
  localparam int EV_TX_DONE   = 5;

  // reset values
  localparam int              BAUD_W       = 13;
  localparam logic [12:0]     RST_BAUD     = 13'h0041;
  localparam logic            RST_TX_EMPTY = 1'b1;
  localparam logic            RST_TX_DONE  = 1'b1;
  localparam logic            RST_LINE     = 1'b1;

  // bit timing in ticks of the 16x baud clock
  localparam logic [3:0]      TQ_SMP_FIRST = 4'h7;
  localparam logic [3:0]      TQ_SMP_LAST  = 4'h9;
  localparam logic [3:0]      TQ_LAST      = 4'hF;
  localparam logic [7:0]      IDLE_TICKS   = 8'hA0;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rx_state_e;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_SHIFT = 2'b10
  } tx_state_e;

  // xor of the low n bits, inverted for odd parity
  function automatic logic frame_parity(input logic [9:0] v, input logic [3:0] n,
                                        input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 10; i++)
      if (i < int'(n))
        p = p ^ v[i];
    return p;
  endfunction

endpackage

// ### uart_rx_sampler.sv
`timescale 1ns/1ps
module uart_rx_sampler
  import uart_flags_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // timing and mode
  input  wire logic       tick,
  input  wire logic       rx_on,
  input  wire logic       wide,
  input  wire logic       par_en,
  input  wire logic       par_odd,
  // line
  input  wire logic       rxd,
  // character out
  output logic            char_valid,
  output logic [8:0]      char_data,
  output logic            char_noise,
  output logic            char_framing,
  output logic            char_parity,
  output logic            idle_seen
);
  typedef struct packed {
    rx_state_e   st;
    logic [3:0]  tq;
    logic [3:0]  bitn;
    logic [2:0]  smp;
    logic        noisy;
    logic [9:0]  sh;
    logic [7:0]  idle_cnt;
    logic        valid;
    logic [8:0]  data;
    logic        noise;
    logic        framing;
    logic        par_err;
    logic        idle_seen;
  } rx_s;

  rx_s        s;
  rx_s        next_s;
  logic [3:0] nbits;
  logic       vote;
  logic       unan;

  always_comb
  begin
    next_s = s;
    next_s.valid = 1'b0;
    next_s.idle_seen = 1'b0;
    nbits = 4'h8 + {3'h0, wide} + {3'h0, par_en};
    // three mid-bit samples, majority decides and any disagreement is noise
    vote = (s.smp[0] & s.smp[1]) | (s.smp[0] & s.smp[2]) | (s.smp[1] & s.smp[2]);
    unan = (&s.smp) | ~(|s.smp);
    if (!rx_on)
    begin
      next_s.st = RX_IDLE;
      next_s.idle_cnt = 8'h00;
    end
    else if (tick)
    begin
      if (s.st != RX_IDLE)
      begin
        next_s.tq = s.tq + 4'h1;
        if (s.tq >= TQ_SMP_FIRST && s.tq <= TQ_SMP_LAST)
          next_s.smp = {rxd, s.smp[2:1]};
      end
      case (s.st)
        RX_IDLE:
          if (!rxd)
          begin
            next_s.st = RX_START;
            next_s.tq = 4'h0;
            next_s.idle_cnt = 8'h00;
          end
          else if (s.idle_cnt != IDLE_TICKS)
          begin
            next_s.idle_cnt = s.idle_cnt + 8'h01;
            next_s.idle_seen = (s.idle_cnt + 8'h01) == IDLE_TICKS;
          end
        RX_START:
          if (s.tq == TQ_LAST)
          begin
            // a start bit that votes high was a glitch
            next_s.st = vote ? RX_IDLE : RX_DATA;
            next_s.bitn = 4'h0;
            next_s.noisy = !unan;
          end
        RX_DATA:
          if (s.tq == TQ_LAST)
          begin
            next_s.sh[s.bitn] = vote;
            next_s.noisy = s.noisy | !unan;
            next_s.bitn = s.bitn + 4'h1;
            if (s.bitn == nbits - 4'h1)
              next_s.st = RX_STOP;
          end
        RX_STOP:
          if (s.tq == TQ_LAST)
          begin
            next_s.st = RX_IDLE;
            next_s.valid = 1'b1;
            next_s.framing = !vote;
            next_s.noise = s.noisy | !unan;
            next_s.par_err = par_en & frame_parity(s.sh, nbits, par_odd);
            next_s.data = wide ? s.sh[8:0] : {1'b0, s.sh[7:0]};
          end
        default:
          next_s.st = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.st <= RX_IDLE;
    end
    else
      s <= next_s;
  end

  assign char_valid   = s.valid;
  assign char_data    = s.data;
  assign char_noise   = s.noise;
  assign char_framing = s.framing;
  assign char_parity  = s.par_err;
  assign idle_seen    = s.idle_seen;
endmodule

// ### uart_tx_shifter.sv
`timescale 1ns/1ps
module uart_tx_shifter
  import uart_flags_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // timing and mode
  input  wire logic       tick,
  input  wire logic       wide,
  input  wire logic       par_en,
  input  wire logic       par_odd,
  // character in
  input  wire logic       load,
  input  wire logic [8:0] load_data,
  // line
  output logic            txd,
  output logic            busy
);
  typedef struct packed {
    tx_state_e   st;
    logic [3:0]  tq;
    logic [3:0]  left;
    logic [11:0] fr;
    logic        txd;
  } tx_s;

  tx_s        s;
  tx_s        next_s;
  logic [3:0] ndat;
  logic [3:0] nbits;
  logic [9:0] v;

  always_comb
  begin
    next_s = s;
    ndat = 4'h8 + {3'h0, wide};
    nbits = ndat + {3'h0, par_en};
    v = {1'b0, wide & load_data[8], load_data[7:0]};
    if (par_en)
      v[ndat] = frame_parity(v, ndat, par_odd);
    next_s.txd = (s.st == TX_SHIFT) ? s.fr[0] : 1'b1;
    case (s.st)
      TX_IDLE:
        if (load)
        begin
          // ones above the last data or parity bit become the stop bit
          next_s.fr = '1;
          next_s.fr[0] = 1'b0;
          for (int i = 0; i < 10; i++)
            if (i < int'(nbits))
              next_s.fr[i + 1] = v[i];
          next_s.left = nbits + 4'h2;
          next_s.tq = 4'h0;
          next_s.st = TX_SHIFT;
        end
      TX_SHIFT:
        if (tick)
        begin
          next_s.tq = s.tq + 4'h1;
          if (s.tq == TQ_LAST)
          begin
            next_s.fr = {1'b1, s.fr[11:1]};
            next_s.left = s.left - 4'h1;
            if (s.left == 4'h1)
              next_s.st = TX_IDLE;
          end
        end
      default:
        next_s.st = TX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.st <= TX_IDLE;
      s.txd <= RST_LINE;
    end
    else
      s <= next_s;
  end

  assign txd  = s.txd;
  assign busy = s.st != TX_IDLE;
endmodule

// ### uart_flags_properties.sv
`timescale 1ns/1ps
module uart_flags_properties
  import uart_flags_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // line and interrupt
  input wire logic        rx_serial_input,
  input wire logic        tx_serial_output,
  input wire logic        irq
);
  logic       acc;
  logic       rd_acc;
  logic [5:0] mask_sh;
  logic       t8_sh;
  logic       txon_sh;
  logic [7:0] hi_cnt;
  assign acc = psel && penable;
  assign rd_acc = acc && !pwrite;
  // shadows of written fields, updated only at the access edge; hi_cnt counts cycles of high transmit line
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      mask_sh <= 6'h00;
      t8_sh <= 1'b0;
      txon_sh <= 1'b0;
      hi_cnt <= 8'h00;
    end
    else
    begin
      hi_cnt <= !tx_serial_output ? 8'h00 : (hi_cnt == 8'hFF ? hi_cnt : hi_cnt + 8'h01);
      if (acc && pwrite && paddr == OFF_EVENT_MASK)
        mask_sh <= pwdata[5:0];
      if (acc && pwrite && paddr == OFF_CTRL_THREE)
        t8_sh <= pwdata[C3_TX_NINTH];
      if (acc && pwrite && paddr == OFF_CTRL_TWO)
        txon_sh <= pwdata[C2_TX_ON];
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence full_seen;
    rd_acc && paddr == OFF_LINE_STATUS && prdata[LS_RX_FULL];
  endsequence
  sequence data_rd;
    rd_acc && paddr == OFF_DATA;
  endsequence
  sequence ls_rd;
    rd_acc && paddr == OFF_LINE_STATUS;
  endsequence
  full_clear_a: assert property (full_seen ##3 data_rd ##3 ls_rd |-> !prdata[LS_RX_FULL])
    else $error("receive full not cleared by status then data read");
  unmapped_err_a: assert property (acc && paddr > 8'h1C |-> pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (acc && paddr <= 8'h1C && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access with error");
  unmapped_zero_a: assert property (rd_acc && paddr > 8'h1C |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  irq_masked_a: assert property (mask_sh == 6'h00 |-> !irq)
    else $error("interrupt while all masked");
  ninth_hold_a: assert property (rd_acc && paddr == OFF_CTRL_THREE |->
    prdata[C3_TX_NINTH] == t8_sh) else $error("ninth transmit bit not held");
  tx_start_a: assert property (acc && pwrite && paddr == OFF_DATA && txon_sh &&
    hi_cnt >= 8'd40 |-> ##[2:4] $fell(tx_serial_output)) else $error("transmit not started");
  irq_clear_a: assert property (acc && pwrite && paddr == OFF_EVENT && mask_sh != 6'h00 &&
    (pwdata[5:0] & mask_sh) == mask_sh |=> !irq) else $error("interrupt not cleared");
  ready_now_a: assert property (acc |-> pready)
    else $error("access phase without ready");
endmodule

bind uart_flags_top uart_flags_properties u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_serial_input(rx_serial_input),
  .tx_serial_output(tx_serial_output), .irq(irq));

// ### uart_peer.sv
`timescale 1ns/1ps
module uart_peer
(
  // clock
  input wire logic pclk,
  // line
  input wire logic txd,
  output logic     rxd
);
  initial rxd = 1'b1;
  // bit time is 16 cycles, divisor 1; bad stop goes high before the stop ends,
  // so the receiver never mistakes it for a new start
  task send(input logic [10:0] b, input int n, input logic bad);
    @(posedge pclk) rxd <= 1'b0;
    repeat (16) @(posedge pclk);
    for (int i = 0; i < n; i++)
    begin
      rxd <= b[i];
      repeat (16) @(posedge pclk);
    end
    rxd <= !bad;
    repeat (13) @(posedge pclk);
    rxd <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
  // samples each bit at its centre, lsb first
  task get(output logic [8:0] w, input int n);
    w = 9'h000;
    @(negedge txd);
    repeat (24) @(posedge pclk);
    for (int i = 0; i < n; i++)
    begin
      w[i] = txd;
      repeat (16) @(posedge pclk);
    end
  endtask
endmodule

// ### async_serial_rx_flags_ninth_bit_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module async_serial_rx_flags_ninth_bit_tb;
  import uart_flags_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic        rx_serial_input, tx_serial_output, irq, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [8:0]  w;
  int          mismatches, tests_run;
  uart_flags_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_serial_input(rx_serial_input),
    .tx_serial_output(tx_serial_output), .irq(irq));
  uart_peer u_peer (.pclk(pclk), .txd(tx_serial_output), .rxd(rx_serial_input));
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
  task rd(input logic [7:0] a); apb(1'b0, a, 32'h0); endtask
  task tick(input int n); repeat (n) @(posedge pclk); endtask
  task chr(input logic [7:0] d); u_peer.send({3'h0, d}, 8, 1'b0); tick(6); endtask
  task t_reset;
    rd(OFF_LINE_STATUS); `CHK(r, 32'h0000_00C0)
    rd(OFF_BAUD); `CHK(r[12:0], RST_BAUD)
    rd(OFF_CTRL_THREE); `CHK(r, 32'h0)
    rd(8'h20); `CHK({err, r}, {1'b1, 32'h0})
    wr(8'h24, 32'hFFFF_FFFF); `CHK(err, 1'b1)
    `CHK(irq, 1'b0)
    wr(OFF_BAUD, 32'h1);
    wr(OFF_CTRL_TWO, 32'h0C);
    $display("test reset done");
  endtask
  task t_rx;
    chr(8'hA5);
    rd(OFF_LINE_STATUS); `CHK(r[5:0], 6'h20)
    rd(OFF_DATA); `CHK(r[7:0], 8'hA5)
    rd(OFF_LINE_STATUS); `CHK(r[LS_RX_FULL], 1'b0)
    chr(8'h3C);
    rd(OFF_DATA); `CHK(r[7:0], 8'h3C)
    rd(OFF_LINE_STATUS); `CHK(r[LS_RX_FULL], 1'b1)
    rd(OFF_DATA);
    rd(OFF_LINE_STATUS); `CHK(r[LS_RX_FULL], 1'b0)
    tick(170);
    rd(OFF_LINE_STATUS); `CHK(r[LS_IDLE_LINE], 1'b1)
    rd(OFF_DATA);
    rd(OFF_LINE_STATUS); `CHK(r[LS_IDLE_LINE], 1'b0)
    tick(300);
    rd(OFF_LINE_STATUS); `CHK(r[LS_IDLE_LINE], 1'b0)
    $display("test rx done");
  endtask
  task t_ovr;
    u_peer.send({3'h0, 8'h11}, 8, 1'b0);
    u_peer.send({3'h0, 8'h22}, 8, 1'b1);
    tick(6);
    rd(OFF_LINE_STATUS); `CHK(r[5:0], 6'h28)
    rd(OFF_DATA); `CHK(r[7:0], 8'h11)
    rd(OFF_LINE_STATUS); `CHK(r[5:0], 6'h00)
    wr(OFF_CTRL_ONE, 32'h03);
    u_peer.send({2'h0, ^8'h5B, 8'h5B}, 9, 1'b1);
    tick(6);
    rd(OFF_LINE_STATUS); `CHK(r[5:0], 6'h23)
    rd(OFF_DATA); `CHK(r[7:0], 8'h5B)
    wr(OFF_CTRL_ONE, 32'h00);
    $display("test errors done");
  endtask
  task t_edge;
    rd(OFF_EVENT); `CHK(r[EV_RX_EDGE], 1'b1)
    wr(OFF_EVENT, 32'h3E); rd(OFF_EVENT); `CHK(r[EV_RX_EDGE], 1'b1)
    wr(OFF_EVENT, 32'h01); rd(OFF_EVENT); `CHK(r[EV_RX_EDGE], 1'b0)
    wr(OFF_CTRL_TWO, 32'h08);
    chr(8'h55);
    rd(OFF_EVENT); `CHK(r[EV_RX_EDGE], 1'b0)
    wr(OFF_CTRL_TWO, 32'h0C);
    wr(OFF_EVENT_MASK, 32'h01);
    tick(1); `CHK(irq, 1'b0)
    chr(8'h55);
    `CHK(irq, 1'b1)
    wr(OFF_EVENT, 32'h01);
    tick(1); `CHK(irq, 1'b0)
    rd(OFF_LINE_STATUS);
    rd(OFF_DATA); `CHK(r[7:0], 8'h55)
    wr(OFF_EVENT_MASK, 32'h00);
    $display("test edge done");
  endtask
  task t_tx;
    wr(OFF_CTRL_ONE, 32'h10);
    wr(OFF_CTRL_THREE, 32'h40);
    wr(OFF_DATA, 32'h5A); u_peer.get(w, 9); `CHK(w, 9'h15A)
    wr(OFF_DATA, 32'h33); u_peer.get(w, 9); `CHK(w, 9'h133)
    rd(OFF_CTRL_THREE); `CHK(r[C3_TX_NINTH], 1'b1)
    u_peer.send({2'h0, 9'h1C3}, 9, 1'b0); tick(6);
    rd(OFF_LINE_STATUS);
    rd(OFF_DATA); `CHK(r[7:0], 8'hC3)
    rd(OFF_CTRL_THREE); `CHK(r[C3_RX_NINTH], 1'b1)
    tick(40);
    wr(OFF_CTRL_THREE, 32'h00);
    wr(OFF_CTRL_ONE, 32'h00);
    wr(OFF_DATA, 32'h0F); u_peer.get(w, 9); `CHK(w, 9'h10F)
    chr(8'h00);
    rd(OFF_LINE_STATUS);
    rd(OFF_DATA); `CHK(r[7:0], 8'h00)
    rd(OFF_CTRL_THREE); `CHK(r[C3_RX_NINTH], 1'b1)
    tick(40);
    rd(OFF_EVENT); `CHK(r[5:4], 2'b11)
    rd(OFF_LINE_STATUS); `CHK(r[7:6], 2'b11)
    `CHK(irq, 1'b0)
    $display("test tx done");
  endtask
  task results;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // whole run needs about 2800 cycles
  initial
  begin
    #2000000;
    mismatches++;
    results();
  end
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0;
    mismatches = 0; tests_run = 0;
    tick(2);
    presetn <= 1'b1;
    t_reset();
    t_rx();
    t_ovr();
    t_edge();
    t_tx();
    results();
  end
endmodule
